// File: cfl_pkg.sv
package cfl_pkg;
    // Bus geometry
    localparam int CFL_ADDR_W = 8;
    localparam int CFL_REG_W = 8;
    localparam int CFL_IDX_W = 6;

    // Register indices; byte address is four times the index
    localparam logic [5:0] CFL_IDX_MUX = 6'h03;
    localparam logic [5:0] CFL_IDX_CTRL = 6'h1D;
    localparam logic [5:0] CFL_IDX_STAT = 6'h1E;

    // analog_mux_reg fields
    localparam int CFL_MUX_HOLD = 7;
    localparam int CFL_MUX_DIVIDED_HOLD_SELECT = 6;
    localparam int CFL_MUX_INV = 5;
    localparam int CFL_MUX_VREF = 4;
    localparam int CFL_MUX_SEL_LSB = 0;
    localparam int CFL_MUX_SEL_W = 4;

    // analog_control fields
    localparam int CFL_CTRL_CHG = 7;
    localparam int CFL_CTRL_ATD2 = 6;
    localparam int CFL_CTRL_ATD1 = 5;
    localparam int CFL_CTRL_CAPTURE_FROM_COMPARATOR_ENABLE = 4;
    localparam int CFL_CTRL_CPIE = 3;
    localparam int CFL_CTRL_CP2EN = 2;
    localparam int CFL_CTRL_CP1EN = 1;
    localparam int CFL_CTRL_ISEN = 0;

    // analog_status fields; bits 7 and 6 are the flag clears on write
    localparam int CFL_STAT_COMPARATOR2_RISE_FLAG = 7;
    localparam int CFL_STAT_COMPARATOR1_RISE_FLAG = 6;
    localparam int CFL_STAT_VOFF = 3;
    localparam int CFL_STAT_COMPARATOR1_PIN_OUTPUT_ENABLE = 2;
    localparam int CFL_STAT_COMPARATOR2_LEVEL = 1;
    localparam int CFL_STAT_COMPARATOR1_LEVEL = 0;

    // Reset values
    localparam logic [7:0] CFL_MUX_RST = 8'h00;
    localparam logic [7:0] CFL_CTRL_RST = 8'h00;
    localparam logic [7:0] CFL_STAT_RST = 8'h00;

    // Comparator input source codes for the analog switch matrix
    localparam logic [2:0] CFL_SRC_PIN0 = 3'h0;
    localparam logic [2:0] CFL_SRC_PIN2 = 3'h2;
    localparam logic [2:0] CFL_SRC_PIN3 = 3'h3;
    localparam logic [2:0] CFL_SRC_CH_MUX = 3'h7;
endpackage : cfl_pkg

// File: cfl_reg_if.sv
`timescale 1ns/1ns
interface cfl_reg_if;
    import cfl_pkg::*;
    logic wr;
    logic [CFL_IDX_W-1:0] idx;
    logic [CFL_REG_W-1:0] wdata;
    logic [CFL_REG_W-1:0] rdata;
    logic hit;
    modport bus (output wr, output idx, output wdata, input rdata, input hit);
    modport regs (input wr, input idx, input wdata, output rdata, output hit);
endinterface : cfl_reg_if

// File: cfl_sync_edge.sv
`timescale 1ns/1ns
module cfl_sync_edge
(
    input wire logic clk,
    input wire logic srst,
    input wire logic raw,
    input wire logic invert,
    output logic level,
    output logic rise
);
    import cfl_pkg::*;

    logic s1;
    logic s2;
    logic s3;
    logic stable;
    logic prev;
    logic next_stable;
    logic next_prev;

    // Filtered level only moves once the second and third stages agree
    always_comb
    begin
        next_stable = stable;
        if (s2 == s3)
        begin
            next_stable = s3;
        end
        next_prev = level;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            stable <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            stable <= next_stable;
            prev <= next_prev;
        end
    end

    // Output sense follows the swap, so a change of invert can make an edge
    assign level = stable ^ invert;
    assign rise = level & ~prev;
endmodule : cfl_sync_edge

// File: cfl_apb_slave.sv
`timescale 1ns/1ns
module cfl_apb_slave
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cfl_pkg::CFL_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    cfl_reg_if.bus rb
);
    import cfl_pkg::*;

    logic ok;
    logic [31:0] next_prdata;

    assign ok = rb.hit && (paddr[1:0] == 2'b00);
    assign rb.idx = paddr[CFL_ADDR_W-1:2];
    assign rb.wdata = pwdata[CFL_REG_W-1:0];
    assign rb.wr = psel & penable & pwrite & ok;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~ok;

    // Read data is captured in the setup cycle so it comes from a flop
    always_comb
    begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite)
        begin
            next_prdata = ok ? {{(32-CFL_REG_W){1'b0}}, rb.rdata} : 32'h00000000;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            prdata <= 32'h00000000;
        end
        else
        begin
            prdata <= next_prdata;
        end
    end
endmodule : cfl_apb_slave

// File: cfl_comparator_flags.sv
`timescale 1ns/1ns
// Contract
// RL1: comparator 1 inputs fixed to pins two, three
// RL2: comparator1_level follows comparator 1 output
// RL3: comparator1_rise_flag sets on rising edge, sticky
// RL4: write one clears comparator1_rise_flag
// RL5: comparator1_rise_flag raises analog interrupt
// RL6: routing enable drives comparator 1 onto pin4
// RL7: routing works only with option_select
// RL8: pin4 is OR of data, timer, comparator
// RL9: software clears other pin4 sources for comparator
// RL10: comparator 2 positive fixed, negative selectable
// RL11: comparator2_level follows comparator 2 output
// RL12: comparator2_rise_flag sets on rising edge, sticky
// RL13: write one clears comparator2_rise_flag
// RL14: comparator2_rise_flag raises analog interrupt
// RL15: comparator 2 rise triggers timer capture
// RL16: divider connected only with divided_hold_select
// RL17: status bits readable in analog status register
// RL18: invert swaps inputs and output sense
// RL19: edges caused by invert still set flags
// RL20: comparator outputs synchronised before use
// RL21: interrupt needs enable and a set flag
module cfl_comparator_flags
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cfl_pkg::CFL_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic comparator1_level_raw,
    input wire logic comparator2_level_raw,
    input wire logic option_select,
    input wire logic port_b_data4,
    input wire logic timer_compare_pin,
    output logic port_b_pin4,
    output logic analog_irq,
    output logic timer_capture_trigger,
    output logic [2:0] comparator1_level_pos_src,
    output logic [2:0] comparator1_level_neg_src,
    output logic [2:0] comparator2_level_pos_src,
    output logic [2:0] comparator2_level_neg_src,
    output logic [cfl_pkg::CFL_MUX_SEL_W-1:0] channel_select,
    output logic divider_connect,
    output logic hold_connect,
    output logic vref_connect,
    output logic [cfl_pkg::CFL_REG_W-1:0] analog_control_out
);
    import cfl_pkg::*;

    cfl_reg_if rb ();

    logic [CFL_REG_W-1:0] analog_mux_reg;
    logic [CFL_REG_W-1:0] analog_control_reg;
    logic comparator1_pin_output_enable;
    logic voltage_off;
    logic [1:0] rise_flag;
    logic [CFL_REG_W-1:0] next_mux;
    logic [CFL_REG_W-1:0] next_ctrl;
    logic next_comparator1_pin_output_enable;
    logic next_voff;
    logic [1:0] next_flag;
    logic [1:0] flag_clear;
    logic [1:0] level;
    logic [1:0] rise;
    logic [1:0] raw;
    logic comparator_invert;
    logic route_on;
    logic next_pin4;
    logic next_irq;
    logic next_capture;
    logic stat_wr;

    assign raw = {comparator2_level_raw, comparator1_level_raw};
    assign comparator_invert = analog_mux_reg[CFL_MUX_INV];

    cfl_apb_slave u_apb
    (
        .clk(clk),
        .srst(srst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .rb(rb.bus)
    );

    // One synchroniser and edge detector per comparator
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_cmp
            cfl_sync_edge u_sync // see RL20 see RL19
            (
                .clk(clk),
                .srst(srst),
                .raw(raw[gi]),
                .invert(comparator_invert),
                .level(level[gi]),
                .rise(rise[gi])
            );
        end
    endgenerate

    // Address decode and read mux
    always_comb
    begin
        rb.hit = 1'b1;
        rb.rdata = '0;
        if (rb.idx == CFL_IDX_MUX)
        begin
            rb.rdata = analog_mux_reg;
        end
        else if (rb.idx == CFL_IDX_CTRL)
        begin
            rb.rdata = analog_control_reg;
        end
        else if (rb.idx == CFL_IDX_STAT)
        begin
            rb.rdata[CFL_STAT_COMPARATOR2_RISE_FLAG] = rise_flag[1]; // see RL17
            rb.rdata[CFL_STAT_COMPARATOR1_RISE_FLAG] = rise_flag[0];
            rb.rdata[CFL_STAT_VOFF] = voltage_off;
            rb.rdata[CFL_STAT_COMPARATOR1_PIN_OUTPUT_ENABLE] = comparator1_pin_output_enable;
            rb.rdata[CFL_STAT_COMPARATOR2_LEVEL] = level[1]; // see RL11
            rb.rdata[CFL_STAT_COMPARATOR1_LEVEL] = level[0]; // see RL2
        end
        else
        begin
            rb.hit = 1'b0;
        end
    end

    assign stat_wr = rb.wr && (rb.idx == CFL_IDX_STAT);
    assign flag_clear[0] = stat_wr & rb.wdata[CFL_STAT_COMPARATOR1_RISE_FLAG];
    assign flag_clear[1] = stat_wr & rb.wdata[CFL_STAT_COMPARATOR2_RISE_FLAG];

    always_comb
    begin
        next_mux = analog_mux_reg;
        next_ctrl = analog_control_reg;
        next_comparator1_pin_output_enable = comparator1_pin_output_enable;
        next_voff = voltage_off;
        if (rb.wr && rb.idx == CFL_IDX_MUX)
        begin
            next_mux = rb.wdata;
        end
        if (rb.wr && rb.idx == CFL_IDX_CTRL)
        begin
            next_ctrl = rb.wdata;
        end
        if (stat_wr)
        begin
            next_comparator1_pin_output_enable = rb.wdata[CFL_STAT_COMPARATOR1_PIN_OUTPUT_ENABLE];
            next_voff = rb.wdata[CFL_STAT_VOFF];
        end
        // A new edge wins over a clear in the same cycle
        next_flag = rise | (rise_flag & ~flag_clear); // see RL3 see RL4 see RL12 see RL13
        next_irq = next_ctrl[CFL_CTRL_CPIE] & (|next_flag); // see RL5 see RL14 see RL21
        next_capture = rise[1] & analog_control_reg[CFL_CTRL_CAPTURE_FROM_COMPARATOR_ENABLE]; // see RL15
    end

    // Comparator 1 reaches the pin only if the mask option allows it
    assign route_on = comparator1_pin_output_enable & option_select; // see RL6 see RL7
    assign next_pin4 = port_b_data4 | timer_compare_pin | (route_on & level[0]); // see RL8 see RL9

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            analog_mux_reg <= CFL_MUX_RST;
            analog_control_reg <= CFL_CTRL_RST;
            comparator1_pin_output_enable <= CFL_STAT_RST[CFL_STAT_COMPARATOR1_PIN_OUTPUT_ENABLE];
            voltage_off <= CFL_STAT_RST[CFL_STAT_VOFF];
            rise_flag <= 2'b00;
            analog_irq <= 1'b0;
            timer_capture_trigger <= 1'b0;
            port_b_pin4 <= 1'b0;
        end
        else
        begin
            analog_mux_reg <= next_mux;
            analog_control_reg <= next_ctrl;
            comparator1_pin_output_enable <= next_comparator1_pin_output_enable;
            voltage_off <= next_voff;
            rise_flag <= next_flag;
            analog_irq <= next_irq;
            timer_capture_trigger <= next_capture;
            port_b_pin4 <= next_pin4;
        end
    end

    // Switch matrix: comparator 1 on fixed pins, comparator 2 pin0 against the channel mux, swapped together when inverted
    assign comparator1_level_pos_src = comparator_invert ? CFL_SRC_PIN3 : CFL_SRC_PIN2; // see RL1 see RL18
    assign comparator1_level_neg_src = comparator_invert ? CFL_SRC_PIN2 : CFL_SRC_PIN3; // see RL1 see RL18
    assign comparator2_level_pos_src = comparator_invert ? CFL_SRC_CH_MUX : CFL_SRC_PIN0; // see RL10 see RL18
    assign comparator2_level_neg_src = comparator_invert ? CFL_SRC_PIN0 : CFL_SRC_CH_MUX; // see RL10 see RL18
    assign channel_select = analog_mux_reg[CFL_MUX_SEL_LSB +: CFL_MUX_SEL_W];
    assign divider_connect = analog_mux_reg[CFL_MUX_DIVIDED_HOLD_SELECT]; // see RL16
    assign hold_connect = analog_mux_reg[CFL_MUX_HOLD];
    assign vref_connect = analog_mux_reg[CFL_MUX_VREF];
    assign analog_control_out = analog_control_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_raw1_high;
        (comparator1_level_raw && !comparator_invert) [*5];
    endsequence

    sequence s_clear1;
        flag_clear[0] && !rise[0];
    endsequence

    sync_level_a: assert property (s_raw1_high |-> level[0]) // see RL20
        else $error("comparator 1 level not high after sync delay");
    flag1_set_a: assert property (rise[0] |=> rise_flag[0] ##1 (rise_flag[0] || $past(flag_clear[0]))) // see RL3
        else $error("comparator 1 flag not set by rising edge");
    flag1_hold_a: assert property (rise_flag[0] && !flag_clear[0] |=> rise_flag[0]) // see RL4
        else $error("comparator 1 flag lost without clear");
    flag1_clear_a: assert property (s_clear1 |=> !rise_flag[0]) // see RL4
        else $error("comparator 1 flag not cleared");
    flag2_setwin_a: assert property (rise[1] && flag_clear[1] |=> rise_flag[1]) // see RL12
        else $error("comparator 2 edge lost under clear");
    flag2_clear_a: assert property (flag_clear[1] && !rise[1] |=> !rise_flag[1]) // see RL13
        else $error("comparator 2 flag not cleared");
    irq_state_a: assert property (analog_irq == (analog_control_reg[CFL_CTRL_CPIE] && (|rise_flag))) // see RL21
        else $error("interrupt does not match enable and flags");
    capture_pulse_a: assert property (rise[1] && analog_control_reg[CFL_CTRL_CAPTURE_FROM_COMPARATOR_ENABLE] |=> timer_capture_trigger) // see RL15
        else $error("capture not triggered by comparator 2 edge");
    capture_cause_a: assert property (timer_capture_trigger |-> $past(rise[1])) // see RL15
        else $error("capture without comparator 2 edge");
    pin4_or_a: assert property (##1 port_b_pin4 == ($past(port_b_data4) | $past(timer_compare_pin) // see RL8
        | ($past(comparator1_pin_output_enable) & $past(option_select) & $past(level[0]))))
        else $error("pin4 is not the OR of its sources");
    pin4_option_a: assert property (!option_select && !port_b_data4 && !timer_compare_pin |=> !port_b_pin4) // see RL7
        else $error("comparator reached pin4 without option");
    divider_a: assert property (!$past(rb.wr) |-> $stable(divider_connect)) // see RL16
        else $error("divider switched without a register write");
endmodule : cfl_comparator_flags

// File: cfl_cmp_model.sv
`timescale 1ns/1ns
module cfl_cmp_model
(
    input wire logic clk,
    input wire logic [1:0] want,
    input wire logic [3:0] lag,
    output logic comparator1_level_raw,
    output logic comparator2_level_raw
);
    logic [1:0] pipe [16];

    initial
    begin
        comparator1_level_raw = 1'b0;
        comparator2_level_raw = 1'b0;
        for (int i = 0; i < 16; i++)
            pipe[i] = 2'b00;
    end

    // Comparator outputs settle after a selectable response time, in clock cycles
    always @(posedge clk)
    begin
        pipe[0] <= want;
        for (int i = 1; i < 16; i++)
            pipe[i] <= pipe[i-1];
        comparator1_level_raw <= pipe[lag][0];
        comparator2_level_raw <= pipe[lag][1];
    end
endmodule : cfl_cmp_model

// File: testbench.sv
`timescale 1ns/1ns
module testbench;
    import cfl_pkg::*;
    localparam logic [7:0] A_MUX = {CFL_IDX_MUX, 2'b00};
    localparam logic [7:0] A_CTRL = {CFL_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_STAT = {CFL_IDX_STAT, 2'b00};
    logic clk, srst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, ctrl_out;
    logic [31:0] pwdata, prdata, rd, r, seed;
    logic comparator1_level_raw, comparator2_level_raw, option_select, port_b_data4, timer_compare_pin;
    logic port_b_pin4, analog_irq, timer_capture_trigger, divider_connect;
    logic [2:0] p1, n1, p2;
    logic [1:0] want;
    logic [3:0] lag;
    logic [7:0] adr [3];
    logic [7:0] rst_v [3];
    int fails, checks, cyc, seen;

    cfl_comparator_flags dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .comparator1_level_raw(comparator1_level_raw), .comparator2_level_raw(comparator2_level_raw), .option_select(option_select),
        .port_b_data4(port_b_data4), .timer_compare_pin(timer_compare_pin), .port_b_pin4(port_b_pin4),
        .analog_irq(analog_irq), .timer_capture_trigger(timer_capture_trigger), .comparator1_level_pos_src(p1),
        .comparator1_level_neg_src(n1), .comparator2_level_pos_src(p2), .comparator2_level_neg_src(), .channel_select(),
        .divider_connect(divider_connect), .hold_connect(), .vref_connect(), .analog_control_out(ctrl_out));

    cfl_cmp_model model_u (.clk(clk), .want(want), .lag(lag), .comparator1_level_raw(comparator1_level_raw), .comparator2_level_raw(comparator2_level_raw));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic pin4_exp(input logic [4:0] v);
        return v[0] | v[1] | (v[2] & v[3] & v[4]);
    endfunction : pin4_exp

    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    task automatic fail(input string msg);
        fails++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask : fail

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp)
            fail($sformatf("%s got %h exp %h", msg, got, exp));
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        checks++;
        if (got !== exp)
            fail($sformatf("%s got %b exp %b", msg, got, exp));
    endtask : chk_bit

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
        logic [31:0] x;
        x = rnd();
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {x[31:8], wd};
        @(posedge clk);
        penable <= 1'b1;
        // This wait ends on the first clock edge that sees pready high
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle();
        repeat (12) @(posedge clk);
    endtask : settle

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (timer_capture_trigger === 1'b1)
            seen++;
        if (cyc > 20000)
        begin
            fail("timeout");
            final_report();
        end
    end

    initial
    begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        want = 2'b00;
        lag = 4'h0;
        option_select = 1'b0;
        port_b_data4 = 1'b0;
        timer_compare_pin = 1'b0;
        seed = 32'h0001666D;
        adr = '{A_MUX, A_CTRL, A_STAT};
        rst_v = '{CFL_MUX_RST, CFL_CTRL_RST, CFL_STAT_RST};
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, adr[i], 8'h00);
            chk_word(rd, {24'h0, rst_v[i]}, "reset value");
        end
        chk_word({23'h0, p1, n1, p2}, {23'h0, CFL_SRC_PIN2, CFL_SRC_PIN3, CFL_SRC_PIN0}, "inputs");
        // Unmapped and unaligned places refuse and leave control alone
        apb(1'b1, 8'h40, 8'hFF);
        chk_bit(err, 1'b1, "unmapped");
        apb(1'b1, A_CTRL | 8'h01, 8'hFF);
        chk_bit(err, 1'b1, "unaligned");
        apb(1'b0, A_CTRL, 8'h00);
        chk_word(rd, 32'h0, "control kept");
        for (int k = 0; k < 4; k++)
        begin
            r = rnd() & 32'hFFDF;
            apb(1'b1, A_MUX, r[7:0]);
            apb(1'b0, A_MUX, 8'h00);
            chk_word(rd, {24'h0, r[7:0]}, "mux readback");
            chk_bit(divider_connect, r[CFL_MUX_DIVIDED_HOLD_SELECT], "divider");
            apb(1'b1, A_CTRL, r[15:8]);
            apb(1'b0, A_CTRL, 8'h00);
            chk_word(rd, {24'h0, r[15:8]}, "control readback");
            chk_word({24'h0, ctrl_out}, {24'h0, r[15:8]}, "control out");
        end
        apb(1'b1, A_MUX, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            lag <= 4'(3 * i);
            apb(1'b1, A_CTRL, 8'h18);
            seen = 0;
            want[i] <= 1'b1;
            settle();
            apb(1'b0, A_STAT, 8'h00);
            chk_word(rd, 32'(8'h41 << i), "rise seen");
            chk_bit(analog_irq, 1'b1, "irq on flag");
            chk_word(32'(seen), 32'(i), "capture pulses");
            want[i] <= 1'b0;
            settle();
            apb(1'b1, A_STAT, 8'h00);
            apb(1'b0, A_STAT, 8'h00);
            chk_word(rd, 32'(8'h40 << i), "flag sticky");
            apb(1'b1, A_CTRL, 8'h00);
            @(posedge clk);
            chk_bit(analog_irq, 1'b0, "irq masked");
            apb(1'b1, A_STAT, 8'(8'h40 << i));
            apb(1'b0, A_STAT, 8'h00);
            chk_word(rd, 32'h0, "flag cleared");
        end
        apb(1'b1, A_CTRL, 8'h08);
        seen = 0;
        apb(1'b1, A_MUX, 8'h20);
        settle();
        apb(1'b0, A_STAT, 8'h00);
        chk_word(rd, 32'hC3, "invert edges");
        chk_bit(analog_irq, 1'b1, "irq both");
        chk_word(32'(seen), 32'h0, "capture off");
        apb(1'b1, A_MUX, 8'h00);
        apb(1'b1, A_STAT, 8'hC0);
        // Bits: data4, timer, routing enable, option, comparator 1 level
        for (int k = 0; k < 16; k++)
        begin
            r = rnd();
            if (k == 0)
                r = 32'h1C;
            port_b_data4 <= r[0];
            timer_compare_pin <= r[1];
            option_select <= r[3];
            want <= {1'b0, r[4]};
            apb(1'b1, A_STAT, {5'h0, r[2], 2'b00});
            settle();
            chk_bit(port_b_pin4, pin4_exp(r[4:0]), "pin4 level");
        end
        final_report();
    end
endmodule : testbench
